// [mowc_chk.sv]
`default_nettype none
module mowc_chk
	import mowc_pkg::*;
(
	input wire logic                      core_clk_i,
	input wire logic                      reset_n_i,
	input wire logic                      clk_en_i,
	input wire logic [MOWC_ADDR_W-1:0]    reg_addr_i,
	input wire logic [MOWC_DATA_W-1:0]    reg_wdata_i,
	input wire logic                      reg_wr_i,
	input wire logic                      reg_rd_i,
	input wire logic [MOWC_DATA_W-1:0]    reg_rdata_o,
	input wire logic [2:0]                first_pulse_src_o,
	input wire logic [2:0]                second_pulse_src_o,
	input wire logic                      period_or_freq_select_o,
	input wire logic                      waveform_sampling_enable_o,
	input wire logic [2:0]                wave_one_src_o,
	input wire logic [2:0]                wave_two_src_o,
	input wire logic [MOWC_RMS_LOW_W-1:0] wave_one_rms_low_o,
	input wire logic                      sample_tick_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [11:0] gap;
	// saturates so a long disabled spell cannot wrap below one period
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) gap <= 12'h000;
		else if (sample_tick_o) gap <= 12'h001;
		else if (gap != 12'hFFF) gap <= gap + 12'h001;
	end
	chk_rdata_idle: assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside read cycle");
	chk_unmapped_read: assert property (clk_en_i && reg_rd_i && reg_addr_i != MOWC_OFS_OUTSRC
		&& reg_addr_i != MOWC_OFS_WAVE |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_shared_sel: assert property ((first_pulse_src_o == MOWC_SRC_APPARENT
		|| second_pulse_src_o == MOWC_SRC_APPARENT) |-> first_pulse_src_o != MOWC_SRC_IRMS
		&& second_pulse_src_o != MOWC_SRC_IRMS) else $error("mixed apparent and rms");
	chk_wave_low: assert property (wave_one_src_o != MOWC_WAV_IRMS_LPF
		&& $past(wave_one_src_o) != MOWC_WAV_IRMS_LPF |-> wave_one_rms_low_o == 24'h000000)
		else $error("rms low sample while unselected");
	chk_tick_off: assert property (!waveform_sampling_enable_o [*2] |-> !sample_tick_o)
		else $error("tick while sampling off");
	chk_tick_gap: assert property (sample_tick_o && gap != 12'h000 |-> gap >= 12'd160)
		else $error("sample ticks too close");
	chk_wr_decode: assert property (clk_en_i && reg_wr_i && reg_addr_i == MOWC_OFS_OUTSRC
		##1 clk_en_i |=> period_or_freq_select_o == $past(reg_wdata_i[1], 2)
		&& waveform_sampling_enable_o == $past(reg_wdata_i[0], 2)) else $error("mode bits late");
	chk_enable_freeze: assert property (!clk_en_i |=> $stable(reg_rdata_o)
		&& $stable(first_pulse_src_o) && $stable(wave_one_src_o) && $stable(sample_tick_o))
		else $error("state moved while clock enable low");
	chk_soft_reset: assert property (clk_en_i && reg_wr_i && reg_addr_i == MOWC_OFS_PRIMARY
		&& reg_wdata_i[MOWC_SOFT_RST_BIT] ##1 clk_en_i |=> second_pulse_src_o == MOWC_SRC_REACTIVE
		&& wave_two_src_o == MOWC_WAV_CURRENT) else $error("soft reset missed");
endmodule : mowc_chk
bind mowc_meter_output_waveform_config mowc_chk mowc_chk_i (.core_clk_i, .reset_n_i,
	.clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .first_pulse_src_o,
	.second_pulse_src_o, .period_or_freq_select_o, .waveform_sampling_enable_o,
	.wave_one_src_o, .wave_two_src_o, .wave_one_rms_low_o, .sample_tick_o);
`default_nettype wire

// [mowc_meter_output_waveform_config.sv]
// The implementer's own choice: strobed register access.
`default_nettype none
// Notes on behaviour
// R1 - second pulse source bits 7:6: 00 active, 01 reactive, 1x apparent or rms
// R2 - second pulse source resets to 01, reactive power
// R3 - first pulse source bits 5:4: 00 active, 01 reactive, 1x apparent or rms
// R4 - bit 3 picks apparent (0) or current rms (1) for any 1x pulse source
// R5 - bit 3 also chooses what feeds apparent energy accumulation
// R6 - both 1x outputs always share one apparent-or-rms choice
// R7 - bit 2 set: rms results refresh only on voltage zero crossing
// R8 - bit 1 selects period (0) or frequency (1) at line period result
// R9 - bit 0 turns waveform sampling mode on or off
// R10 - wave two source bits 7:5, reset 000, codes 000..101, rest reserved
// R11 - wave one source bits 4:2, same encoding, rest reserved
// R12 - wave one rms low-pass source delivers only its low 24 bits
// R13 - rate bits 1:0 divide 819.2 kHz by 32, 64, 128 or 256
// R14 - soft reset bit in primary mode register restores both registers
// R15 - software avoids reserved wave codes and absent reactive selections
// R16 - reads return last written value; settings reach the outputs two cycles after write
module mowc_meter_output_waveform_config
	import mowc_pkg::*;
#(
	parameter int RMS_W = 32
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   clk_en_i,
	input  wire logic [MOWC_ADDR_W-1:0] reg_addr_i,
	input  wire logic [MOWC_DATA_W-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	input  wire logic                   voltage_zero_cross_i,
	input  wire logic [RMS_W-1:0]       irms_lpf_i,
	output logic [MOWC_DATA_W-1:0]      reg_rdata_o,
	output logic [2:0]                  first_pulse_src_o,
	output logic [2:0]                  second_pulse_src_o,
	output logic                        apparent_energy_is_rms_o,
	output logic                        rms_update_strobe_o,
	output logic                        period_or_freq_select_o,
	output logic                        waveform_sampling_enable_o,
	output logic [2:0]                  wave_one_src_o,
	output logic [2:0]                  wave_two_src_o,
	output logic [MOWC_RMS_LOW_W-1:0]   wave_one_rms_low_o,
	output logic                        sample_tick_o
);
	// the rms low-pass sample needs at least the low 24 bits of the filter value
	if (RMS_W < MOWC_RMS_LOW_W) begin : g_rms_w_check
		$error("RMS_W must be at least 24");
	end

	localparam int DIV_W = MOWC_RATE_BASE_LOG + 3 + 3;

	logic [MOWC_DATA_W-1:0] output_source_mode;
	logic [MOWC_DATA_W-1:0] waveform_sample_mode;
	logic                   zx_meta;
	logic                   zx_sync;
	logic                   zx_prev;
	logic [2:0]             core_div_cnt;
	logic [DIV_W-1:0]       rate_cnt;
	logic                   wr_outsrc;
	logic                   wr_wave;
	logic                   soft_reset;
	logic                   base_tick;
	logic [DIV_W-1:0]       rate_last;
	logic [2:0]             next_first_src;
	logic [2:0]             next_second_src;
	logic [2:0]             next_wave_one;
	logic [2:0]             next_wave_two;

	assign wr_outsrc  = reg_wr_i && (reg_addr_i == MOWC_OFS_OUTSRC);
	assign wr_wave    = reg_wr_i && (reg_addr_i == MOWC_OFS_WAVE);
	assign soft_reset = reg_wr_i && (reg_addr_i == MOWC_OFS_PRIMARY)
		&& reg_wdata_i[MOWC_SOFT_RST_BIT];

	// soft reset takes priority so one write cannot leave half the bank stale
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			output_source_mode <= MOWC_OUTSRC_RST; // R2
		end else if (clk_en_i) begin
			if (soft_reset) begin
				output_source_mode <= MOWC_OUTSRC_RST; // R14
			end else if (wr_outsrc) begin
				output_source_mode <= reg_wdata_i; // R16
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			waveform_sample_mode <= MOWC_WAVE_RST; // R10
		end else if (clk_en_i) begin
			if (soft_reset) begin
				waveform_sample_mode <= MOWC_WAVE_RST; // R14
			end else if (wr_wave) begin
				waveform_sample_mode <= reg_wdata_i; // R16
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= '0;
		end else if (clk_en_i) begin
			if (reg_rd_i && reg_addr_i == MOWC_OFS_OUTSRC) begin
				reg_rdata_o <= output_source_mode; // R16
			end else if (reg_rd_i && reg_addr_i == MOWC_OFS_WAVE) begin
				reg_rdata_o <= waveform_sample_mode; // R16
			end else begin
				reg_rdata_o <= '0;
			end
		end
	end

	function automatic logic [2:0] pulse_src(input logic [1:0] sel, input logic use_rms);
		logic [2:0] r;
		r = MOWC_SRC_ACTIVE;
		if (sel[1]) begin
			r = use_rms ? MOWC_SRC_IRMS : MOWC_SRC_APPARENT; // R4 R6
		end else if (sel[0]) begin
			r = MOWC_SRC_REACTIVE;
		end
		return r;
	endfunction : pulse_src

	function automatic logic [2:0] wave_src(input logic [2:0] code);
		logic [2:0] r;
		r = MOWC_WAV_RESERVED;
		if (code <= 3'(MOWC_WAV_IRMS_LPF)) begin
			r = code;
		end
		return r;
	endfunction : wave_src

	// both pulse outputs read the same bit 3, so they can never disagree
	always_comb begin
		next_first_src  = pulse_src(output_source_mode[MOWC_CF1_HI:MOWC_CF1_LO],
			output_source_mode[MOWC_VARMS_BIT]); // R3
		next_second_src = pulse_src(output_source_mode[MOWC_CF2_HI:MOWC_CF2_LO],
			output_source_mode[MOWC_VARMS_BIT]); // R1
		next_wave_one   = wave_src(waveform_sample_mode[MOWC_W1_HI:MOWC_W1_LO]); // R11
		next_wave_two   = wave_src(waveform_sample_mode[MOWC_W2_HI:MOWC_W2_LO]); // R10
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			first_pulse_src_o          <= MOWC_SRC_ACTIVE;
			second_pulse_src_o         <= MOWC_SRC_REACTIVE;
			apparent_energy_is_rms_o   <= 1'b0;
			period_or_freq_select_o    <= 1'b0;
			waveform_sampling_enable_o <= 1'b0;
			wave_one_src_o             <= MOWC_WAV_CURRENT;
			wave_two_src_o             <= MOWC_WAV_CURRENT;
		end else if (clk_en_i) begin
			first_pulse_src_o          <= next_first_src;
			second_pulse_src_o         <= next_second_src;
			apparent_energy_is_rms_o   <= output_source_mode[MOWC_VARMS_BIT]; // R5
			period_or_freq_select_o    <= output_source_mode[MOWC_PERIOD_OR_FREQ_SELECT_BIT]; // R8
			waveform_sampling_enable_o <= output_source_mode[MOWC_WAVEFORM_SAMPLING_ENABLE_BIT]; // R9
			wave_one_src_o             <= next_wave_one;
			wave_two_src_o             <= next_wave_two;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wave_one_rms_low_o <= '0;
		end else if (clk_en_i) begin
			if (waveform_sample_mode[MOWC_W1_HI:MOWC_W1_LO] == 3'(MOWC_WAV_IRMS_LPF)) begin
				wave_one_rms_low_o <= irms_lpf_i[MOWC_RMS_LOW_W-1:0]; // R12
			end else begin
				wave_one_rms_low_o <= '0;
			end
		end
	end

	// zero-cross arrives from the analog front end, so synchronise first
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			zx_meta <= 1'b0;
			zx_sync <= 1'b0;
			zx_prev <= 1'b0;
		end else if (clk_en_i) begin
			zx_meta <= voltage_zero_cross_i;
			zx_sync <= zx_meta;
			zx_prev <= zx_sync;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rms_update_strobe_o <= 1'b0;
		end else if (clk_en_i) begin
			if (output_source_mode[MOWC_RMS_UPDATE_ON_ZERO_CROSS_BIT]) begin
				rms_update_strobe_o <= zx_sync && !zx_prev; // R7
			end else begin
				rms_update_strobe_o <= 1'b1;
			end
		end
	end

	assign base_tick = (core_div_cnt == 3'(MOWC_CORE_DIV - 1));
	assign rate_last = DIV_W'((1 << (MOWC_RATE_BASE_LOG
		+ int'(waveform_sample_mode[MOWC_RATE_HI:MOWC_RATE_LO]))) - 1);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_div_cnt <= '0;
		end else if (clk_en_i) begin
			core_div_cnt <= base_tick ? 3'h0 : core_div_cnt + 3'h1;
		end
	end

	// a rate change restarts the count, avoiding one very short first period
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rate_cnt      <= '0;
			sample_tick_o <= 1'b0;
		end else if (clk_en_i) begin
			sample_tick_o <= 1'b0;
			if (wr_wave || soft_reset) begin
				rate_cnt <= '0;
			end else if (base_tick) begin
				if (rate_cnt >= rate_last) begin
					rate_cnt      <= '0;
					sample_tick_o <= output_source_mode[MOWC_WAVEFORM_SAMPLING_ENABLE_BIT]; // R13
				end else begin
					rate_cnt <= rate_cnt + DIV_W'(1);
				end
			end
		end
	end
endmodule : mowc_meter_output_waveform_config
`default_nettype wire

// [mowc_pkg.sv]
`default_nettype none
package mowc_pkg;
	localparam int          MOWC_ADDR_W        = 7;
	localparam int          MOWC_DATA_W        = 8;
	localparam logic [6:0]  MOWC_OFS_PRIMARY   = 7'h0B;
	localparam logic [6:0]  MOWC_OFS_OUTSRC    = 7'h0C;
	localparam logic [6:0]  MOWC_OFS_WAVE      = 7'h0D;
	localparam logic [6:0]  MOWC_OFS_LINE_PER  = 7'h0A;
	localparam logic [7:0]  MOWC_OUTSRC_RST    = 8'h40;
	localparam logic [7:0]  MOWC_WAVE_RST      = 8'h00;
	localparam logic [7:0]  MOWC_PRIMARY_RST   = 8'h06;
	localparam int          MOWC_SOFT_RST_BIT  = 7;
	localparam int          MOWC_CF2_HI        = 7;
	localparam int          MOWC_CF2_LO        = 6;
	localparam int          MOWC_CF1_HI        = 5;
	localparam int          MOWC_CF1_LO        = 4;
	localparam int          MOWC_VARMS_BIT     = 3;
	localparam int          MOWC_RMS_UPDATE_ON_ZERO_CROSS_BIT     = 2;
	localparam int          MOWC_PERIOD_OR_FREQ_SELECT_BIT   = 1;
	localparam int          MOWC_WAVEFORM_SAMPLING_ENABLE_BIT     = 0;
	localparam int          MOWC_W2_HI         = 7;
	localparam int          MOWC_W2_LO         = 5;
	localparam int          MOWC_W1_HI         = 4;
	localparam int          MOWC_W1_LO         = 2;
	localparam int          MOWC_RATE_HI       = 1;
	localparam int          MOWC_RATE_LO       = 0;
	localparam int          MOWC_CORE_DIV      = 5;
	localparam int          MOWC_RATE_BASE_LOG = 5;
	localparam int          MOWC_RMS_LOW_W     = 24;
	typedef enum logic [2:0] {
		MOWC_SRC_ACTIVE,
		MOWC_SRC_REACTIVE,
		MOWC_SRC_APPARENT,
		MOWC_SRC_IRMS
	} mowc_pulse_src_t;
	typedef enum logic [2:0] {
		MOWC_WAV_CURRENT,
		MOWC_WAV_VOLTAGE,
		MOWC_WAV_ACTIVE,
		MOWC_WAV_REACTIVE,
		MOWC_WAV_APPARENT,
		MOWC_WAV_IRMS_LPF,
		MOWC_WAV_RESERVED
	} mowc_wave_src_t;
endpackage : mowc_pkg
`default_nettype wire

// [tb_mowc_meter_output_waveform_config.sv]
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_mowc_meter_output_waveform_config
	import mowc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct { logic [6:0] a; logic [7:0] d; logic [2:0] x, y; } mowc_row_t;
	logic        core_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1;
	logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, voltage_zero_cross_i = 1'b0;
	logic [6:0]  reg_addr_i = 7'h00;
	logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
	logic [31:0] irms_lpf_i = 32'hA5123456;
	logic [2:0]  first_pulse_src_o, second_pulse_src_o, wave_one_src_o, wave_two_src_o;
	logic        apparent_energy_is_rms_o, rms_update_strobe_o, period_or_freq_select_o;
	logic        waveform_sampling_enable_o, sample_tick_o;
	logic [23:0] wave_one_rms_low_o;
	int          error_cnt = 0, check_count = 0, n;
	// x is first pulse or wave one, y second pulse or wave two
	mowc_row_t   rows [13] = '{'{7'h0C, 8'h0B, 0, 0}, '{7'h0C, 8'h50, 1, 1},
		'{7'h0C, 8'hA0, 2, 2}, '{7'h0C, 8'hE8, 3, 3}, '{7'h0C, 8'h28, 3, 0},
		'{7'h0C, 8'h90, 1, 2}, '{7'h0D, 8'h24, 1, 1}, '{7'h0D, 8'h48, 2, 2},
		'{7'h0D, 8'h6C, 3, 3}, '{7'h0D, 8'h94, 5, 4}, '{7'h0D, 8'hB0, 4, 5},
		'{7'h0D, 8'hFC, 6, 6}, '{7'h0D, 8'h00, 0, 0}};
	mowc_meter_output_waveform_config mowc_meter_output_waveform_config_i (.core_clk_i,
		.reset_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.voltage_zero_cross_i, .irms_lpf_i, .reg_rdata_o, .first_pulse_src_o, .second_pulse_src_o,
		.apparent_energy_is_rms_o, .rms_update_strobe_o, .period_or_freq_select_o,
		.waveform_sampling_enable_o, .wave_one_src_o, .wave_two_src_o, .wave_one_rms_low_o,
		.sample_tick_o);
	always #10 core_clk_i = ~core_clk_i;
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(reg_rdata_o, e)
	endtask : rd
	task automatic check_rst();
		rd(MOWC_OFS_OUTSRC, MOWC_OUTSRC_RST);
		rd(MOWC_OFS_WAVE, MOWC_WAVE_RST);
		`CHK(second_pulse_src_o, 3'd1)
	endtask : check_rst
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// about twice the roughly five thousand cycles the sequence needs
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		check_rst();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			if (rows[i].a == MOWC_OFS_OUTSRC) begin
				`CHK(first_pulse_src_o, rows[i].x)
				`CHK(second_pulse_src_o, rows[i].y)
				`CHK({apparent_energy_is_rms_o, period_or_freq_select_o}, rows[i].d[3:2] ^ {1'b0, rows[i].d[2]} | {1'b0, rows[i].d[1]})
				`CHK(waveform_sampling_enable_o, rows[i].d[0])
			end else begin
				`CHK(wave_one_src_o, rows[i].x)
				`CHK(wave_two_src_o, rows[i].y)
			end
			rd(rows[i].a, rows[i].d);
		end
		`CHK(wave_one_rms_low_o, 24'h000000)
		wr(MOWC_OFS_WAVE, 8'h14);
		@(posedge core_clk_i);
		#1;
		`CHK(wave_one_rms_low_o, 24'h123456)
		wr(7'h0E, 8'hFF);
		rd(MOWC_OFS_WAVE, 8'h14);
		rd(MOWC_OFS_LINE_PER, 8'h00);
		@(posedge core_clk_i);
		clk_en_i <= 1'b0;
		wr(MOWC_OFS_WAVE, 8'h24);
		@(posedge core_clk_i);
		clk_en_i <= 1'b1;
		#1;
		`CHK(wave_one_src_o, 3'd5)
		rd(MOWC_OFS_WAVE, 8'h14);
		wr(MOWC_OFS_OUTSRC, 8'h04);
		@(posedge core_clk_i);
		voltage_zero_cross_i <= 1'b1;
		n = 0;
		repeat (8) begin
			@(negedge core_clk_i);
			n += (rms_update_strobe_o === 1'b1);
		end
		`CHK(n, 1)
		wr(MOWC_OFS_OUTSRC, 8'h01);
		`CHK(rms_update_strobe_o, 1'b1)
		for (int r = 0; r < 4; r++) begin
			wr(MOWC_OFS_WAVE, 8'(r));
			n = 0;
			while (sample_tick_o !== 1'b1 && n < 3000) begin
				@(negedge core_clk_i);
				n++;
			end
			n = 0;
			do begin
				@(negedge core_clk_i);
				n++;
			end while (sample_tick_o !== 1'b1 && n < 3000);
			`CHK(n, MOWC_CORE_DIV << (MOWC_RATE_BASE_LOG + r))
		end
		wr(MOWC_OFS_PRIMARY, 8'h80);
		check_rst();
		wr(MOWC_OFS_OUTSRC, 8'h90);
		wr(MOWC_OFS_WAVE, 8'hB0);
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		check_rst();
		end_of_test();
	end
endmodule : tb_mowc_meter_output_waveform_config
`default_nettype wire
